// [jfc_defines.svh]
`ifndef JFC_DEFINES_SVH
`define JFC_DEFINES_SVH

// generic instruction width of the tap core
`define JFC_IR_WIDTH_DEFAULT 1

// command port: instruction width and codes
`define JFC_CMD_IR_WIDTH     3
`define JFC_INSTR_BYPASS     3'h0
`define JFC_INSTR_PUSH       3'h1
`define JFC_INSTR_POP        3'h2
`define JFC_INSTR_FLUSH      3'h3

// data path
`define JFC_DATA_WIDTH       8
`define JFC_FIFO_ADDR_WIDTH  4
`define JFC_BUF_DEPTH        2

// both fifo ports run from the one system clock
`define JFC_CLK_HZ           50000000
`define JFC_WR_CLK_HZ        50000000
`define JFC_RD_CLK_HZ        50000000

`endif

// [jfc_pkg.sv]
package jfc_pkg;

  typedef enum logic [3:0] {
    st_tlr,
    st_rti,
    st_sdrs,
    st_cdr,
    st_sdr,
    st_e1dr,
    st_pdr,
    st_e2dr,
    st_udr,
    st_sirs,
    st_cir,
    st_sir,
    st_e1ir,
    st_pir,
    st_e2ir,
    st_uir
  } jfc_tap_state_t;

endpackage : jfc_pkg

// [jfc_fifo_mem.sv]
`timescale 1ns/1ps
`include "jfc_defines.svh"

// single-clock fifo; write and read side share ref_clk
module jfc_fifo_mem
  import jfc_pkg::*;
#(
  parameter int unsigned DATA_W = `JFC_DATA_WIDTH,
  parameter int unsigned ADDR_W = `JFC_FIFO_ADDR_WIDTH
) (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              wr_en,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   rd_valid,
  output logic                   empty,
  output logic                   full
);

  typedef struct packed {
    logic [ADDR_W:0]   wp;
    logic [ADDR_W:0]   rp;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
    logic              empty;
    logic              full;
  } jfc_fifo_st_t;

  jfc_fifo_st_t      st_r;
  jfc_fifo_st_t      st_nxt;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic              do_wr;
  logic              do_rd;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    do_wr         = wr_en && !st_r.full;
    do_rd         = rd_en && !st_r.empty;
    if (do_wr) begin
      st_nxt.wp = (ADDR_W+1)'(st_r.wp + 1'b1);
    end
    if (do_rd) begin
      st_nxt.rp     = (ADDR_W+1)'(st_r.rp + 1'b1);
      st_nxt.rdata  = mem[st_r.rp[ADDR_W-1:0]];
      st_nxt.rvalid = 1'b1;
    end
    st_nxt.empty = (st_nxt.wp == st_nxt.rp);
    st_nxt.full  = (st_nxt.wp[ADDR_W] != st_nxt.rp[ADDR_W]) &&
                   (st_nxt.wp[ADDR_W-1:0] == st_nxt.rp[ADDR_W-1:0]);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r       <= '0;
      st_r.empty <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge ref_clk) begin
    if (do_wr) begin
      mem[st_r.wp[ADDR_W-1:0]] <= wr_data;
    end
  end

  assign rd_data  = st_r.rdata;
  assign rd_valid = st_r.rvalid;
  assign empty    = st_r.empty;
  assign full     = st_r.full;

endmodule : jfc_fifo_mem

// [jfc_tap_core.sv]
`timescale 1ns/1ps
`include "jfc_defines.svh"

// tap controller with user instruction register and state flags
module jfc_tap_core
  import jfc_pkg::*;
#(
  parameter int unsigned instruction_width_param = `JFC_IR_WIDTH_DEFAULT
) (
  input  wire logic                               ref_clk,
  input  wire logic                               rstn,
  input  wire logic                               tck_rise,
  input  wire logic                               tck_fall,
  input  wire logic                               tms_bit,
  input  wire logic                               tdi_bit,
  input  wire logic                               user_tdo,
  input  wire logic [instruction_width_param-1:0] instruction_capture_value,
  output logic      [instruction_width_param-1:0] captured_instruction,
  output logic                                    user_dr_capture_flag,
  output logic                                    user_dr_shift_flag,
  output logic                                    user_dr_exit1_flag,
  output logic                                    user_dr_pause_flag,
  output logic                                    user_dr_exit2_flag,
  output logic                                    user_dr_update_flag,
  output logic                                    user_ir_capture_flag,
  output logic                                    user_ir_update_flag,
  output logic                                    tdo
);

  localparam int unsigned IW = instruction_width_param;

  typedef struct packed {
    jfc_tap_state_t st;
    logic [IW-1:0]  ir_sh;
    logic [IW-1:0]  ir;
    logic           cdr;
    logic           sdr;
    logic           e1dr;
    logic           pdr;
    logic           e2dr;
    logic           udr;
    logic           cir;
    logic           uir;
    logic           tdo;
  } jfc_core_st_t;

  jfc_core_st_t st_r;
  jfc_core_st_t st_nxt;

  function automatic jfc_tap_state_t tap_next(input jfc_tap_state_t s, input logic tms);
    case (s)
      st_tlr:  tap_next = tms ? st_tlr  : st_rti;
      st_rti:  tap_next = tms ? st_sdrs : st_rti;
      st_sdrs: tap_next = tms ? st_sirs : st_cdr;
      st_cdr:  tap_next = tms ? st_e1dr : st_sdr;
      st_sdr:  tap_next = tms ? st_e1dr : st_sdr;
      st_e1dr: tap_next = tms ? st_udr  : st_pdr;
      st_pdr:  tap_next = tms ? st_e2dr : st_pdr;
      st_e2dr: tap_next = tms ? st_udr  : st_sdr;
      st_udr:  tap_next = tms ? st_sdrs : st_rti;
      st_sirs: tap_next = tms ? st_tlr  : st_cir;
      st_cir:  tap_next = tms ? st_e1ir : st_sir;
      st_sir:  tap_next = tms ? st_e1ir : st_sir;
      st_e1ir: tap_next = tms ? st_uir  : st_pir;
      st_pir:  tap_next = tms ? st_e2ir : st_pir;
      st_e2ir: tap_next = tms ? st_uir  : st_sir;
      st_uir:  tap_next = tms ? st_sdrs : st_rti;
      default: tap_next = st_tlr;
    endcase
  endfunction : tap_next

  always_comb begin
    logic [IW:0] sh_tmp;
    sh_tmp = {tdi_bit, st_r.ir_sh};
    st_nxt = st_r;
    if (tck_rise) begin
      case (st_r.st)
        st_cir:  st_nxt.ir_sh = instruction_capture_value;
        st_sir:  st_nxt.ir_sh = sh_tmp[IW:1];
        default: ;                                          // pause holds
      endcase
      st_nxt.st = tap_next(st_r.st, tms_bit);
    end
    if (tck_fall) begin
      if (st_r.st == st_uir) begin
        st_nxt.ir = st_r.ir_sh;
      end
      if (st_r.st == st_sir) begin
        st_nxt.tdo = st_r.ir_sh[0];
      end else if (st_r.st == st_sdr) begin
        st_nxt.tdo = user_tdo;
      end
    end
    if (st_nxt.st == st_tlr) begin
      st_nxt.ir = '0;
    end
    st_nxt.cdr  = (st_nxt.st == st_cdr);
    st_nxt.sdr  = (st_nxt.st == st_sdr);
    st_nxt.e1dr = (st_nxt.st == st_e1dr);
    st_nxt.pdr  = (st_nxt.st == st_pdr);
    st_nxt.e2dr = (st_nxt.st == st_e2dr);
    st_nxt.udr  = (st_nxt.st == st_udr);
    st_nxt.cir  = (st_nxt.st == st_cir);
    st_nxt.uir  = (st_nxt.st == st_uir);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r    <= '0;
      st_r.st <= st_tlr;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign captured_instruction = st_r.ir;
  assign user_dr_capture_flag = st_r.cdr;
  assign user_dr_shift_flag   = st_r.sdr;
  assign user_dr_exit1_flag   = st_r.e1dr;
  assign user_dr_pause_flag   = st_r.pdr;
  assign user_dr_exit2_flag   = st_r.e2dr;
  assign user_dr_update_flag  = st_r.udr;
  assign user_ir_capture_flag = st_r.cir;
  assign user_ir_update_flag  = st_r.uir;
  assign tdo                  = st_r.tdo;

endmodule : jfc_tap_core

// [jfc_port.sv]
// Contract
// - tms sampled at tck rise steers state
// - test-logic-reset keeps all scan logic inactive
// - run-test/idle holds while tms low
// - select states last one tck, pick branch
// - capture loads shift register from hold
// - shift moves one bit per tck
// - exit1 goes to update or pause
// - pause halts shifting, keeps contents
// - exit2 may advance to update
// - update loads hold on falling tck; the push write instead follows the rise into update-dr
// - instruction out/in buses of parameter width
// - instruction width defaults to one bit
// - separate flags for user dr/ir states
// - three-bit ir: push, pop, flush
// - push writes exactly one fifo value
// - pop reads exactly one fifo value
// - flush reads in burst until empty
// - push chain shifts only push and shift
// - one write pulse after update-dr rises
// - write and read side both 50 MHz
`timescale 1ns/1ps
`include "jfc_defines.svh"

module jfc_port
  import jfc_pkg::*;
#(
  parameter int unsigned DATA_W = `JFC_DATA_WIDTH,
  parameter int unsigned FIFO_AW = `JFC_FIFO_ADDR_WIDTH
) (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  output logic                   tdo,
  output logic      [DATA_W-1:0] out_data,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic                   fifo_empty,
  output logic                   fifo_full
);

  localparam int unsigned IW = `JFC_CMD_IR_WIDTH;

  typedef struct packed {
    logic [2:0]        s1;
    logic [2:0]        s2;
    logic              tck_d;
    logic [DATA_W-1:0] push_sh;
    logic [DATA_W-1:0] pop_sh;
    logic [DATA_W-1:0] pop_hold;
    logic              byp;
    logic              udr_d;
    logic              uir_d;
    logic              wr_en;
    logic [DATA_W-1:0] wr_data;
    logic              pop_pend;
    logic              rd_fly;
    logic [DATA_W-1:0] b0;
    logic [DATA_W-1:0] b1;
    logic [1:0]        cnt;
    logic              ovalid;
  } jfc_port_st_t;

  jfc_port_st_t      st_r;
  jfc_port_st_t      st_nxt;

  logic              tck_rise;
  logic              tck_fall;
  logic              tms_bit;
  logic              tdi_bit;
  logic              user_tdo;
  logic [IW-1:0]     instr;
  logic              cdr_flag;
  logic              sdr_flag;
  logic              udr_flag;
  logic              uir_flag;
  logic              is_push;
  logic              is_pop;
  logic              is_flush;
  logic              rd_en;
  logic [DATA_W-1:0] f_rdata;
  logic              f_rvalid;
  logic              f_empty;
  logic              f_full;
  logic              can_rd;
  logic              buf_pop;

  // pins are sampled twice; edges come from the second stage only
  assign tck_rise = st_r.s2[2] & ~st_r.tck_d;
  assign tck_fall = ~st_r.s2[2] & st_r.tck_d;
  assign tms_bit  = st_r.s2[1];
  assign tdi_bit  = st_r.s2[0];

  assign is_push  = (instr == `JFC_INSTR_PUSH);
  assign is_pop   = (instr == `JFC_INSTR_POP);
  assign is_flush = (instr == `JFC_INSTR_FLUSH);

  // chain feeding the core's scan output
  always_comb begin
    if (is_push) begin
      user_tdo = st_r.push_sh[0];
    end else if (is_pop) begin
      user_tdo = st_r.pop_sh[0];
    end else begin
      user_tdo = st_r.byp;
    end
  end

  jfc_tap_core #(
    .instruction_width_param (IW)
  ) u_core (
    .ref_clk                   (ref_clk),
    .rstn                      (rstn),
    .tck_rise                  (tck_rise),
    .tck_fall                  (tck_fall),
    .tms_bit                   (tms_bit),
    .tdi_bit                   (tdi_bit),
    .user_tdo                  (user_tdo),
    .instruction_capture_value (instr),
    .captured_instruction      (instr),
    .user_dr_capture_flag      (cdr_flag),
    .user_dr_shift_flag        (sdr_flag),
    .user_dr_exit1_flag        (),
    .user_dr_pause_flag        (),
    .user_dr_exit2_flag        (),
    .user_dr_update_flag       (udr_flag),
    .user_ir_capture_flag      (),
    .user_ir_update_flag       (uir_flag),
    .tdo                       (tdo)
  );

  jfc_fifo_mem #(
    .DATA_W (DATA_W),
    .ADDR_W (FIFO_AW)
  ) u_fifo (
    // both fifo ports run on this block's clock; no crossing inside the fifo
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .wr_en    (st_r.wr_en),
    .wr_data  (st_r.wr_data),
    .rd_en    (rd_en),
    .rd_data  (f_rdata),
    .rd_valid (f_rvalid),
    .empty    (f_empty),
    .full     (f_full)
  );

  // one read in flight at a time, and only while the buffer has a free slot
  assign can_rd  = !st_r.rd_fly && (st_r.cnt < 2'(`JFC_BUF_DEPTH));
  assign rd_en   = can_rd && !f_empty && (st_r.pop_pend || is_flush);
  assign buf_pop = st_r.ovalid && out_ready;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.s1    = {tck, tms, tdi};
    st_nxt.s2    = st_r.s1;
    st_nxt.tck_d = st_r.s2[2];

    // user data chains act on the sampled rising tck edge
    if (tck_rise) begin
      if (cdr_flag) begin
        st_nxt.pop_sh = st_r.pop_hold;
        st_nxt.byp    = 1'b0;
      end
      if (sdr_flag) begin
        if (is_push) begin
          st_nxt.push_sh = {tdi_bit, st_r.push_sh[DATA_W-1:1]};
        end
        if (is_pop) begin
          st_nxt.pop_sh = {tdi_bit, st_r.pop_sh[DATA_W-1:1]};
        end
        st_nxt.byp = tdi_bit;
      end
    end

    // single write strobe on the rising update-dr flag
    st_nxt.udr_d = udr_flag;
    st_nxt.wr_en = 1'b0;
    if (udr_flag && !st_r.udr_d && is_push) begin
      st_nxt.wr_en   = 1'b1;
      st_nxt.wr_data = st_r.push_sh;
    end

    // a pop is armed once the new instruction is latched, i.e. leaving update-ir
    st_nxt.uir_d = uir_flag;
    if (st_r.pop_pend && (rd_en || f_empty)) begin
      st_nxt.pop_pend = 1'b0;
    end
    if (st_r.uir_d && !uir_flag && is_pop) begin
      st_nxt.pop_pend = 1'b1;
    end
    st_nxt.rd_fly = rd_en;

    if (f_rvalid) begin
      st_nxt.pop_hold = f_rdata;
    end

    // two-entry output buffer; receiver stalls never drop a word
    if (buf_pop) begin
      st_nxt.b0  = st_r.b1;
      st_nxt.cnt = 2'(st_r.cnt - 2'd1);
    end
    if (f_rvalid) begin
      if (st_nxt.cnt == 2'd0) begin
        st_nxt.b0 = f_rdata;
      end else begin
        st_nxt.b1 = f_rdata;
      end
      st_nxt.cnt = 2'(st_nxt.cnt + 2'd1);
    end
    st_nxt.ovalid = (st_nxt.cnt != 2'd0);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign out_data   = st_r.b0;
  assign out_valid  = st_r.ovalid;
  assign fifo_empty = f_empty;
  assign fifo_full  = f_full;

endmodule : jfc_port

// [jfc_port_asserts.sv]
`timescale 1ns/1ps

module jfc_port_asserts #(
  parameter int unsigned DATA_W  = 8,
  parameter int unsigned FIFO_AW = 4
) (
  input wire logic              ref_clk,
  input wire logic              rstn,
  input wire logic              tck,
  input wire logic              tms,
  input wire logic              tdi,
  input wire logic              tdo,
  input wire logic [DATA_W-1:0] out_data,
  input wire logic              out_valid,
  input wire logic              out_ready,
  input wire logic              fifo_empty,
  input wire logic              fifo_full
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  reset_idle_a: assert property (
    $rose(rstn) |-> fifo_empty && !fifo_full && !out_valid && !tdo)
    else $error("outputs not idle after reset");
  hold_data_a: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled word changed");
  drop_taken_a: assert property ($fell(out_valid) |-> $past(out_ready))
    else $error("word dropped without being taken");
  flags_excl_a: assert property (!(fifo_empty && fifo_full))
    else $error("fifo empty and full together");
  tdo_timing_a: assert property ($changed(tdo) |-> !$past(tck, 2))
    else $error("tdo changed outside the tck low phase");
  empty_read_a: assert property ($rose(fifo_empty) |-> ##[0:3] out_valid)
    else $error("fifo emptied without a word out");
  word_source_a: assert property (
    $rose(out_valid) |-> !$past(fifo_empty, 2) || !$past(fifo_empty, 3))
    else $error("word shown from an empty fifo");
  full_read_a: assert property ($fell(fifo_full) |-> ##[0:3] out_valid)
    else $error("fifo left full without a word out");
endmodule : jfc_port_asserts

bind jfc_port jfc_port_asserts #(.DATA_W(DATA_W), .FIFO_AW(FIFO_AW)) u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
  .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
  .fifo_empty(fifo_empty), .fifo_full(fifo_full));

// [jfc_host_model.sv]
`timescale 1ns/1ps

// scan host: tck stands low between frames, 5 ref_clk low and 3 high within
module jfc_host_model (
  input  wire logic ref_clk,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // tms and tdi settle four ref_clk before the rise; tdo taken just before it
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge ref_clk);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge ref_clk);
    q = tdo;
    tck <= 1'b1;
    repeat (3) @(posedge ref_clk);
    tck <= 1'b0;
  endtask : step

  task automatic walk(input logic [7:0] path, input int n);
    logic q;
    for (int i = 0; i < n; i++) step(path[i], 1'b0, q);
  endtask : walk

  task automatic reset_tap();
    walk(8'h1f, 6);
  endtask : reset_tap

  // from idle: one ir or dr scan, lsb first, optional pause after pause_at bits
  task automatic scan(input logic ir, input logic [7:0] din, input int n,
                      input int pause_at, output logic [7:0] dout);
    logic q;
    dout = 8'h00;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == pause_at - 1, din[i], q);
      dout[i] = q;
      if (i == pause_at - 1 && i != n - 1) walk(8'h04, 4);
    end
    walk(8'h01, 2);
    tdi <= ~tdi;
  endtask : scan
endmodule : jfc_host_model

// [jfc_port_bench.sv]
`timescale 1ns/1ps
`include "jfc_defines.svh"

module jfc_port_bench;
  import jfc_pkg::*;

  typedef struct packed {
    logic [7:0] din;
    logic [7:0] exp;
  } jfc_row_t;

  logic       ref_clk;
  logic       rstn;
  logic       tck;
  logic       tms;
  logic       tdi;
  logic       tdo;
  logic [7:0] out_data;
  logic       out_valid;
  logic       out_ready;
  logic       fifo_empty;
  logic       fifo_full;
  int         num_errors = 0;
  int         total_checks = 0;
  int         cycles = 0;
  jfc_row_t   rows [8] = '{'{8'hea, 8'hea}, '{8'heb, 8'heb}, '{8'hec, 8'hec},
    '{8'hed, 8'hed}, '{8'hee, 8'hee}, '{8'hef, 8'hef}, '{8'hdf, 8'hdf},
    '{8'he0, 8'he0}};

  jfc_port #(.DATA_W(8), .FIFO_AW(4)) u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
    .fifo_empty(fifo_empty), .fifo_full(fifo_full));

  jfc_host_model u_host (
    .ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;

  task automatic close_out();
    $display("checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic check_val(input string what, input logic [7:0] exp,
                           input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check_val

  // wait for a word, compare it, then accept it with a one-cycle ready
  task automatic take_word(input logic [7:0] exp);
    int n;
    n = 0;
    while (out_valid !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    check_val("out_data", exp, out_data);
    out_ready <= 1'b1;
    @(posedge ref_clk);
    out_ready <= 1'b0;
    @(posedge ref_clk);
  endtask : take_word

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    logic [7:0] d;
    rstn = 1'b0;
    out_ready = 1'b0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    check_val("idle flags", 8'h08, {4'h0, fifo_empty, fifo_full, out_valid, tdo});
    check_val("idle data", 8'h00, out_data);
    u_host.reset_tap();
    u_host.scan(1'b1, 8'(`JFC_INSTR_PUSH), 3, 0, d);
    check_val("captured ir", 8'h00, d);
    u_host.reset_tap();
    u_host.scan(1'b0, 8'h55, 8, 0, d);
    repeat (8) @(posedge ref_clk);
    check_val("fifo_empty", 8'h01, {7'h00, fifo_empty});
    u_host.scan(1'b1, 8'(`JFC_INSTR_PUSH), 3, 0, d);
    check_val("captured ir", 8'h00, d);
    foreach (rows[i]) u_host.scan(1'b0, rows[i].din, 8, 0, d);
    u_host.scan(1'b1, 8'(`JFC_INSTR_FLUSH), 3, 0, d);
    check_val("captured ir", 8'h01, d);
    repeat (20) @(posedge ref_clk);
    check_val("stall flags", 8'h01, {6'h00, fifo_empty, out_valid});
    foreach (rows[i]) take_word(rows[i].exp);
    repeat (8) @(posedge ref_clk);
    check_val("drained", 8'h02, {6'h00, fifo_empty, out_valid});
    u_host.scan(1'b0, 8'h01, 3, 0, d);
    check_val("bypass", 8'h01, {6'h00, d[2:1]});
    u_host.scan(1'b1, 8'(`JFC_INSTR_PUSH), 3, 0, d);
    check_val("captured ir", 8'h03, d);
    for (int i = 0; i < 17; i++) u_host.scan(1'b0, 8'(8'h80 + i), 8, 0, d);
    check_val("full", 8'h01, {6'h00, fifo_empty, fifo_full});
    u_host.scan(1'b1, 8'(`JFC_INSTR_POP), 3, 0, d);
    take_word(8'h80);
    repeat (20) @(posedge ref_clk);
    check_val("one pop", 8'h00, {6'h00, fifo_full, out_valid});
    u_host.scan(1'b0, 8'h00, 8, 3, d);
    check_val("pop chain", 8'h80, d);
    // reset in mid-run: fifo and instruction both return to idle
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check_val("reset flags", 8'h08, {4'h0, fifo_empty, fifo_full, out_valid, tdo});
    check_val("reset data", 8'h00, out_data);
    rstn <= 1'b1;
    u_host.reset_tap();
    u_host.scan(1'b1, 8'(`JFC_INSTR_POP), 3, 0, d);
    check_val("ir after reset", 8'h00, d);
    repeat (20) @(posedge ref_clk);
    check_val("reset pop", 8'h02, {6'h00, fifo_empty, out_valid});
    close_out();
  end
endmodule : jfc_port_bench
